// ---- design/drive_cmd_pkg.sv ----
// constants and types for the host command configuration block
package drive_cmd_pkg;
  // power-up mode codes
  localparam logic [3:0] MD_LEGACY     = 4'h1;
  localparam logic [3:0] MD_CMD_EN     = 4'h2;
  localparam logic [3:0] MD_TUNING     = 4'h3;
  localparam logic [3:0] MD_HUB        = 4'h4;
  localparam logic [3:0] MD_CMD_DIS    = 4'h5;
  localparam logic [3:0] MD_UNUSED     = 4'h6;
  localparam logic [3:0] MD_AUTORUN    = 4'h7;
  localparam logic [3:0] MD_MB_EN      = 4'h8;
  localparam logic [3:0] MD_MB_AUTO    = 4'h9;
  localparam logic [3:0] MD_MB_DIS     = 4'hA;
  localparam logic [3:0] MD_RESET_VAL  = 4'h2;
  // protocol word
  localparam int unsigned PROTO_W      = 9;
  localparam logic [8:0] PROTO_RESET   = 9'h001;
  localparam logic [8:0] PROTO_MIN     = 9'h001;
  localparam int unsigned PB_STD       = 0;
  localparam int unsigned PB_ADDR      = 1;
  localparam int unsigned PB_ACK       = 2;
  localparam int unsigned PB_CSUM      = 3;
  localparam int unsigned PB_REG3      = 5;
  localparam int unsigned PB_CSUM_TYPE = 6;
  localparam int unsigned PB_LITTLE    = 7;
  localparam int unsigned PB_FULL_DUP  = 8;
  // peak current, 0.01 A units
  localparam int unsigned PEAK_W       = 12;
  localparam logic [11:0] PEAK_RESET   = 12'h000;
  // command queue
  localparam int unsigned CMD_W        = 8;
  localparam int unsigned Q_DEPTH      = 8;
  localparam int unsigned Q_AW         = 3;
  localparam logic [3:0] Q_DEPTH_CNT   = 4'h8;
  // escape handshake window: 2 s at 125 MHz
  localparam longint unsigned ESC_WINDOW_MS = 2000;
  localparam longint unsigned CLK_HZ        = 125000000;
  localparam longint unsigned ESC_CYCLES    = ESC_WINDOW_MS * CLK_HZ / 1000;
  localparam logic [7:0] ESC_CHAR      = 8'h30;
  // probe duration (plain default)
  localparam logic [15:0] PROBE_CYCLES = 16'h0400;

  typedef enum logic [2:0] {
    ESC_IDLE  = 3'b001,
    ESC_WAIT1 = 3'b010,
    ESC_WAIT2 = 3'b100
  } esc_state_t;
endpackage : drive_cmd_pkg

// ---- design/cmd_queue_if.sv ----
// interface between the controller and its command queue
`timescale 1ns/1ps
interface cmd_queue_if;
  logic [7:0] push_data;
  logic       push;
  logic       pop;
  logic [7:0] head_data;
  logic       empty;
  logic       full;
  logic [3:0] vacancy;
  modport ctrl (output push_data, output push, output pop,
                input head_data, input empty, input full, input vacancy);
  modport queue (input push_data, input push, input pop,
                 output head_data, output empty, output full, output vacancy);
endinterface : cmd_queue_if

// ---- design/cmd_queue.sv ----
// ordered store for buffered commands
`timescale 1ns/1ps
module cmd_queue (
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  nrst_in,
  // queue side
  cmd_queue_if.queue q
);
  logic [7:0] mem_reg [8];
  logic [2:0] wr_reg;
  logic [2:0] rd_reg;
  logic [3:0] cnt_reg;
  wire        do_push = q.push && (cnt_reg != drive_cmd_pkg::Q_DEPTH_CNT);
  wire        do_pop  = q.pop && (cnt_reg != 4'h0);

  assign q.head_data = mem_reg[rd_reg];
  assign q.empty     = (cnt_reg == 4'h0);
  assign q.full      = (cnt_reg == drive_cmd_pkg::Q_DEPTH_CNT);
  assign q.vacancy   = drive_cmd_pkg::Q_DEPTH_CNT - cnt_reg;

  // storage has no reset; only pointers matter
  always_ff @(posedge clk_in) begin
    if (do_push) mem_reg[wr_reg] <= q.push_data;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_reg  <= 3'h0;
      rd_reg  <= 3'h0;
      cnt_reg <= 4'h0;
    end else begin
      if (do_push) wr_reg <= wr_reg + 3'h1;
      if (do_pop) rd_reg <= rd_reg + 3'h1;
      cnt_reg <= cnt_reg + {3'h0, do_push} - {3'h0, do_pop};
    end
  end
endmodule : cmd_queue

// ---- design/drive_host_command_config.sv ----
// host command configuration: mode selector, escape, protocol, queue, probe
// Summary of operation
// - decode mode codes 1..10 except 6 into legacy, command, tuning, hub, modbus, autorun
// - mode write commits to non-volatile storage at once
// - mode 2 acts like 7 but skips stored program autorun
// - modes 1 and 3 ignore host commands unless escape succeeded
// - "00" within two seconds of power-up packet forces command mode
// - legacy download sets mode 1; upload or execute leaves it
// - protocol held as 9-bit word, valid 1 to 511
// - protocol query replies with the current word
// - bits 1 address prefix, 2 ack/nak, 4 reserved, 5 three-digit addressing
// - bit 0 selects standard protocol only when all other bits clear
// - bit 3 requires message checksum
// - bit 6 selects checksum algorithm
// - bit 7 selects little-endian modbus words
// - bit 8 selects full duplex on four-wire link
// - pause stops execution of buffered commands until continue
// - paused queue keeps accepting; continue runs them in order
// - report free queue slots on request
// - probe energises motor at maximum current, measures inductance and resistance
// - probe runs at power-up, after feedback config, and on request
// - saved peak current in 0.01 A units, stored at once
`timescale 1ns/1ps
module drive_host_command_config #(
  parameter longint unsigned ESC_CYCLES = drive_cmd_pkg::ESC_CYCLES
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // host character stream (already on this clock)
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_char_in,
  input  wire logic        powerup_packet_sent_in,
  // decoded host commands
  input  wire logic        cmd_valid_in,
  input  wire logic        mode_write_in,
  input  wire logic [3:0]  mode_value_in,
  input  wire logic        legacy_download_in,
  input  wire logic        proto_write_in,
  input  wire logic        proto_query_in,
  input  wire logic [8:0]  proto_value_in,
  input  wire logic        pause_queue_in,
  input  wire logic        continue_queue_in,
  input  wire logic        queue_vacancy_query_in,
  input  wire logic        buffered_push_in,
  input  wire logic [7:0]  buffered_cmd_in,
  input  wire logic        exec_ready_in,
  input  wire logic        motor_probe_request_in,
  input  wire logic        feedback_config_command_in,
  input  wire logic        probe_done_in,
  input  wire logic        saved_peak_current_write_in,
  input  wire logic [11:0] saved_peak_current_in,
  // stored settings and decoded mode
  output logic [3:0]  power_up_mode_select_out,
  output logic        nv_write_out,
  output logic        mode_error_out,
  output logic        cmd_lang_active_out,
  output logic        cmd_accept_out,
  output logic        modbus_mode_out,
  output logic        autorun_out,
  output logic        hub_mode_out,
  output logic        drive_enable_out,
  // protocol
  output logic [8:0]  protocol_word_out,
  output logic        proto_reply_valid_out,
  output logic [8:0]  proto_reply_out,
  output logic        proto_standard_out,
  output logic        proto_addr_prefix_out,
  output logic        proto_ack_nak_out,
  output logic        proto_reg3_out,
  output logic        proto_checksum_out,
  output logic        proto_csum_alt_out,
  output logic        proto_little_endian_out,
  output logic        proto_full_duplex_out,
  // queue
  output logic        queue_paused_out,
  output logic        exec_valid_out,
  output logic [7:0]  exec_cmd_out,
  output logic        queue_full_out,
  output logic        vacancy_valid_out,
  output logic [3:0]  vacancy_out,
  // probe and peak current
  output logic        probe_active_out,
  output logic        probe_max_current_out,
  output logic [11:0] peak_current_out
);
  //////////////////////////////////////////////////////////////////////////////
  cmd_queue_if qif ();
  cmd_queue u_queue (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .q       (qif.queue)
  );

  logic [3:0]  mode_reg;
  logic        nv_reg;
  logic        err_reg;
  logic        escaped_reg;
  logic        lang_reg;
  logic        accept_reg;
  logic        modbus_reg;
  logic        autorun_reg;
  logic        hub_reg;
  logic        enable_reg;
  logic [8:0]  proto_reg;
  logic        prv_reg;
  logic [8:0]  prd_reg;
  logic [7:0]  proto_dec_reg;
  logic        paused_reg;
  logic        exv_reg;
  logic [7:0]  exc_reg;
  logic        full_reg;
  logic        vv_reg;
  logic [3:0]  vac_reg;
  logic        probe_reg;
  logic        boot_reg;
  logic [11:0] peak_reg;
  drive_cmd_pkg::esc_state_t esc_reg;
  drive_cmd_pkg::esc_state_t esc_next;
  logic [27:0] esc_cnt_reg;

  //////////////////////////////////////////////////////////////////////////////
  // mode decoding
  wire mode_ok = (mode_value_in >= drive_cmd_pkg::MD_LEGACY)
              && (mode_value_in <= drive_cmd_pkg::MD_MB_DIS)
              && (mode_value_in != drive_cmd_pkg::MD_UNUSED);
  wire mode_take = mode_write_in && mode_ok;
  wire [3:0] mode_next = legacy_download_in ? drive_cmd_pkg::MD_LEGACY
                       : mode_take ? mode_value_in : mode_reg;
  wire gated_mode = (mode_reg == drive_cmd_pkg::MD_LEGACY)
                 || (mode_reg == drive_cmd_pkg::MD_TUNING);
  wire lang_next = (mode_reg == drive_cmd_pkg::MD_CMD_EN)
                || (mode_reg == drive_cmd_pkg::MD_CMD_DIS)
                || (mode_reg == drive_cmd_pkg::MD_AUTORUN)
                || escaped_reg;
  wire mb_next = (mode_reg == drive_cmd_pkg::MD_MB_EN)
              || (mode_reg == drive_cmd_pkg::MD_MB_AUTO)
              || (mode_reg == drive_cmd_pkg::MD_MB_DIS);
  // autorun only for 7 and 9; mode 2 shares 7's behaviour otherwise
  wire ar_next = (mode_reg == drive_cmd_pkg::MD_AUTORUN)
              || (mode_reg == drive_cmd_pkg::MD_MB_AUTO);
  wire en_next = (mode_reg != drive_cmd_pkg::MD_CMD_DIS)
              && (mode_reg != drive_cmd_pkg::MD_MB_DIS);
  wire accept_now = cmd_valid_in && (!gated_mode || escaped_reg);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_reg    <= drive_cmd_pkg::MD_RESET_VAL;
      nv_reg      <= 1'b0;
      err_reg     <= 1'b0;
      lang_reg    <= 1'b0;
      accept_reg  <= 1'b0;
      modbus_reg  <= 1'b0;
      autorun_reg <= 1'b0;
      hub_reg     <= 1'b0;
      enable_reg  <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      nv_reg      <= mode_take || legacy_download_in
                  || saved_peak_current_write_in;
      err_reg     <= mode_write_in && !mode_ok;
      lang_reg    <= lang_next;
      accept_reg  <= accept_now;
      modbus_reg  <= mb_next;
      autorun_reg <= ar_next;
      hub_reg     <= (mode_reg == drive_cmd_pkg::MD_HUB);
      enable_reg  <= en_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // startup escape: "00" with no carriage return inside the window
  wire esc_zero    = rx_valid_in && (rx_char_in == drive_cmd_pkg::ESC_CHAR);
  wire esc_timeout = (esc_cnt_reg >= ESC_CYCLES[27:0]);

  always_comb begin
    esc_next = esc_reg;
    unique case (esc_reg)
      drive_cmd_pkg::ESC_IDLE: begin
        if (powerup_packet_sent_in) esc_next = drive_cmd_pkg::ESC_WAIT1;
      end
      drive_cmd_pkg::ESC_WAIT1: begin
        if (esc_timeout) esc_next = drive_cmd_pkg::ESC_IDLE;
        else if (esc_zero) esc_next = drive_cmd_pkg::ESC_WAIT2;
        else if (rx_valid_in) esc_next = drive_cmd_pkg::ESC_IDLE;
      end
      drive_cmd_pkg::ESC_WAIT2: begin
        // a timeout, or any character other than the second "0", voids the attempt
        if (esc_timeout || rx_valid_in) esc_next = drive_cmd_pkg::ESC_IDLE;
      end
      default: esc_next = drive_cmd_pkg::ESC_IDLE;
    endcase
  end

  wire esc_hit = (esc_reg == drive_cmd_pkg::ESC_WAIT2) && esc_zero && !esc_timeout;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      esc_reg     <= drive_cmd_pkg::ESC_IDLE;
      esc_cnt_reg <= 28'h0;
      escaped_reg <= 1'b0;
    end else begin
      esc_reg     <= esc_hit ? drive_cmd_pkg::ESC_IDLE : esc_next;
      esc_cnt_reg <= (esc_reg == drive_cmd_pkg::ESC_IDLE) ? 28'h0 : esc_cnt_reg + 28'h1;
      if (esc_hit) escaped_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // protocol word
  wire proto_ok = (proto_value_in >= drive_cmd_pkg::PROTO_MIN);
  wire [8:0] p  = proto_reg;
  wire others   = |p[8:1];

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      proto_reg <= drive_cmd_pkg::PROTO_RESET;
      prv_reg   <= 1'b0;
      prd_reg   <= 9'h000;
      proto_dec_reg <= 8'h00;
    end else begin
      if (proto_write_in && proto_ok) proto_reg <= proto_value_in;
      prv_reg <= proto_query_in;
      if (proto_query_in) prd_reg <= proto_reg;
      proto_dec_reg <= {
        !others && p[drive_cmd_pkg::PB_STD],
        p[drive_cmd_pkg::PB_ADDR],
        p[drive_cmd_pkg::PB_ACK],
        p[drive_cmd_pkg::PB_REG3],
        p[drive_cmd_pkg::PB_CSUM],
        p[drive_cmd_pkg::PB_CSUM_TYPE],
        p[drive_cmd_pkg::PB_LITTLE],
        p[drive_cmd_pkg::PB_FULL_DUP]
      };
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // buffered command queue: pause holds execution, pushes continue
  assign qif.push_data = buffered_cmd_in;
  assign qif.push      = buffered_push_in;
  wire   issue         = !paused_reg && !qif.empty && (!exv_reg || exec_ready_in);
  assign qif.pop       = issue;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      paused_reg <= 1'b0;
      exv_reg    <= 1'b0;
      exc_reg    <= 8'h00;
      full_reg   <= 1'b0;
      vv_reg     <= 1'b0;
      vac_reg    <= drive_cmd_pkg::Q_DEPTH_CNT;
    end else begin
      // continue wins when both arrive together
      if (continue_queue_in) paused_reg <= 1'b0;
      else if (pause_queue_in) paused_reg <= 1'b1;
      if (issue) begin
        exv_reg <= 1'b1;
        exc_reg <= qif.head_data;
      end else if (exec_ready_in) begin
        exv_reg <= 1'b0;
      end
      full_reg <= qif.full;
      vv_reg   <= queue_vacancy_query_in;
      if (queue_vacancy_query_in) vac_reg <= qif.vacancy;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // motor probe and saved peak current
  logic [15:0] probe_cnt_reg;
  wire probe_start = boot_reg || motor_probe_request_in || feedback_config_command_in;
  wire probe_end   = probe_done_in || (probe_cnt_reg == drive_cmd_pkg::PROBE_CYCLES);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_reg      <= 1'b1;
      probe_reg     <= 1'b0;
      probe_cnt_reg <= 16'h0000;
      peak_reg      <= drive_cmd_pkg::PEAK_RESET;
    end else begin
      boot_reg <= 1'b0;
      if (probe_reg && probe_end) begin
        probe_reg <= 1'b0;
      end else if (probe_start) begin
        probe_reg     <= 1'b1;
        probe_cnt_reg <= 16'h0000;
      end
      if (probe_reg && !probe_end) probe_cnt_reg <= probe_cnt_reg + 16'h0001;
      if (saved_peak_current_write_in) peak_reg <= saved_peak_current_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign power_up_mode_select_out = mode_reg;
  assign nv_write_out             = nv_reg;
  assign mode_error_out           = err_reg;
  assign cmd_lang_active_out      = lang_reg;
  assign cmd_accept_out           = accept_reg;
  assign modbus_mode_out          = modbus_reg;
  assign autorun_out              = autorun_reg;
  assign hub_mode_out             = hub_reg;
  assign drive_enable_out         = enable_reg;
  assign protocol_word_out        = proto_reg;
  assign proto_reply_valid_out    = prv_reg;
  assign proto_reply_out          = prd_reg;
  assign proto_standard_out       = proto_dec_reg[7];
  assign proto_addr_prefix_out    = proto_dec_reg[6];
  assign proto_ack_nak_out        = proto_dec_reg[5];
  assign proto_reg3_out           = proto_dec_reg[4];
  assign proto_checksum_out       = proto_dec_reg[3];
  assign proto_csum_alt_out       = proto_dec_reg[2];
  assign proto_little_endian_out  = proto_dec_reg[1];
  assign proto_full_duplex_out    = proto_dec_reg[0];
  assign queue_paused_out         = paused_reg;
  assign exec_valid_out           = exv_reg;
  assign exec_cmd_out             = exc_reg;
  assign queue_full_out           = full_reg;
  assign vacancy_valid_out        = vv_reg;
  assign vacancy_out              = vac_reg;
  assign probe_active_out         = probe_reg;
  assign probe_max_current_out    = probe_reg;
  assign peak_current_out         = peak_reg;
endmodule : drive_host_command_config

// ---- test/host_cmd_sva.sv ----
// checker for the host command configuration ports
`timescale 1ns/1ps
module host_cmd_sva (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        nrst_in,
  // watched inputs
  input wire logic        mode_write_in,
  input wire logic [3:0]  mode_value_in,
  input wire logic        legacy_download_in,
  input wire logic        proto_write_in,
  input wire logic        proto_query_in,
  input wire logic [8:0]  proto_value_in,
  input wire logic        exec_ready_in,
  input wire logic        motor_probe_request_in,
  input wire logic        saved_peak_current_write_in,
  input wire logic [11:0] saved_peak_current_in,
  // watched outputs
  input wire logic [3:0]  power_up_mode_select_out,
  input wire logic        nv_write_out,
  input wire logic        mode_error_out,
  input wire logic        autorun_out,
  input wire logic        cmd_lang_active_out,
  input wire logic [8:0]  protocol_word_out,
  input wire logic        proto_reply_valid_out,
  input wire logic [8:0]  proto_reply_out,
  input wire logic        proto_standard_out,
  input wire logic        proto_checksum_out,
  input wire logic        proto_little_endian_out,
  input wire logic        proto_full_duplex_out,
  input wire logic        queue_paused_out,
  input wire logic        exec_valid_out,
  input wire logic [7:0]  exec_cmd_out,
  input wire logic        probe_active_out,
  input wire logic        probe_max_current_out,
  input wire logic [11:0] peak_current_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire bad_code = (mode_value_in == 4'h0) || (mode_value_in == 4'h6) || (mode_value_in > 4'hA);
  ////////////////////////////////////////////////////////////////////////////////
  a_mode_commit: assert property (mode_write_in && !bad_code && !legacy_download_in
    |=> power_up_mode_select_out == $past(mode_value_in) && nv_write_out) else $error("mode lost");
  a_mode_reject: assert property (mode_write_in && bad_code && !legacy_download_in
    |=> mode_error_out && $stable(power_up_mode_select_out)) else $error("bad mode taken");
  a_legacy_sets: assert property (legacy_download_in
    |=> power_up_mode_select_out == 4'h1 && nv_write_out) else $error("download mode");
  a_mode_decode: assert property (power_up_mode_select_out inside {4'h2, 4'h7}
    |=> cmd_lang_active_out && autorun_out == ($past(power_up_mode_select_out) == 4'h7))
    else $error("mode decode");
  a_proto_write: assert property (proto_write_in |=> protocol_word_out ==
    (($past(proto_value_in) == 9'h000) ? $past(protocol_word_out) : $past(proto_value_in)))
    else $error("protocol word");
  // decode lags the word by one cycle, so skip the first edge after reset
  a_proto_bits: assert property ($past(nrst_in) |->
    proto_checksum_out == $past(protocol_word_out[3]) &&
    proto_little_endian_out == $past(protocol_word_out[7]) &&
    proto_full_duplex_out == $past(protocol_word_out[8]) &&
    proto_standard_out == ($past(protocol_word_out) == 9'h001)) else $error("protocol bits");
  a_proto_reply: assert property (proto_query_in && !proto_write_in
    |=> proto_reply_valid_out && proto_reply_out == $past(protocol_word_out)) else $error("reply");
  a_exec_hold: assert property (exec_valid_out && !exec_ready_in
    |=> exec_valid_out && $stable(exec_cmd_out)) else $error("issue dropped");
  a_pause_hold: assert property (queue_paused_out ##1 queue_paused_out
    |-> !$rose(exec_valid_out)) else $error("issued while paused");
  a_peak_save: assert property (saved_peak_current_write_in
    |=> peak_current_out == $past(saved_peak_current_in) && nv_write_out) else $error("peak");
  a_probe_start: assert property (motor_probe_request_in
    |=> probe_active_out && probe_max_current_out) else $error("probe not started");
  c_issue: cover property (exec_valid_out && exec_ready_in);
  c_reject: cover property (mode_error_out);
  c_reply: cover property (proto_reply_valid_out);
endmodule : host_cmd_sva
bind drive_host_command_config host_cmd_sva chk (.*);

// ---- test/exec_model.sv ----
// executor model that takes issued commands, with optional stalling
`timescale 1ns/1ps
module exec_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // issue side
  input  wire logic       valid_in,
  input  wire logic [7:0] cmd_in,
  input  wire logic       slow_in,
  output logic            ready_out
);
  logic [1:0] tick_reg;
  logic [7:0] got[$];
  // slow mode takes one cycle in four so the issuer must hold its command
  assign ready_out = !slow_in || (tick_reg == 2'h3);
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_reg <= 2'h0;
    end else begin
      tick_reg <= tick_reg + 2'h1;
      if (valid_in && ready_out) got.push_back(cmd_in);
    end
  end
endmodule : exec_model

// ---- test/tb_drive_host_command_config.sv ----
// self-checking bench for the host command configuration block
`timescale 1ns/1ps
module tb_drive_host_command_config;
  localparam logic [14:0] MW = 15'h0001, LD = 15'h0002, PW = 15'h0004, PQ = 15'h0008,
    PA = 15'h0010, CO = 15'h0020, VQ = 15'h0040, PU = 15'h0080, RQ = 15'h0100,
    FB = 15'h0200, PD = 15'h0400, PK = 15'h0800, CV = 15'h1000, RX = 15'h2000, UP = 15'h4000;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic slow = 1'b1;
  logic [14:0] pl = 15'h0000;
  logic [11:0] val = 12'h000;
  wire mode_write_in = pl[0], legacy_download_in = pl[1], proto_write_in = pl[2];
  wire proto_query_in = pl[3], pause_queue_in = pl[4], continue_queue_in = pl[5];
  wire queue_vacancy_query_in = pl[6], buffered_push_in = pl[7], motor_probe_request_in = pl[8];
  wire feedback_config_command_in = pl[9], probe_done_in = pl[10];
  wire saved_peak_current_write_in = pl[11], cmd_valid_in = pl[12], rx_valid_in = pl[13];
  wire powerup_packet_sent_in = pl[14], exec_ready_in;
  wire [3:0] mode_value_in = val[3:0];
  wire [8:0] proto_value_in = val[8:0];
  wire [7:0] buffered_cmd_in = val[7:0], rx_char_in = val[7:0];
  wire [11:0] saved_peak_current_in = val;
  logic [3:0] power_up_mode_select_out, vacancy_out;
  logic [8:0] protocol_word_out, proto_reply_out;
  logic [7:0] exec_cmd_out;
  logic [11:0] peak_current_out;
  logic nv_write_out, mode_error_out, cmd_lang_active_out, cmd_accept_out, modbus_mode_out;
  logic autorun_out, hub_mode_out, drive_enable_out, proto_reply_valid_out, proto_standard_out;
  logic proto_addr_prefix_out, proto_ack_nak_out, proto_reg3_out, proto_checksum_out;
  logic proto_csum_alt_out, proto_little_endian_out, proto_full_duplex_out, queue_paused_out;
  logic exec_valid_out, queue_full_out, vacancy_valid_out, probe_active_out, probe_max_current_out;
  int num_errors = 0;
  int n_checks = 0;
  logic [3:0] m_exp;
  logic [8:0] p_exp;
  logic [8:0] pv[7] = '{9'h004, 9'h005, 9'h001, 9'h000, 9'h1C8, 9'h026, 9'h1FF};
  int w;
  ////////////////////////////////////////////////////////////////////////////////
  // escape window shortened so the run stays short
  drive_host_command_config #(.ESC_CYCLES(50)) DUT (.*);
  exec_model partner (.clk_in(clk_in), .nrst_in(nrst_in), .valid_in(exec_valid_out),
    .cmd_in(exec_cmd_out), .slow_in(slow), .ready_out(exec_ready_in));
  always #4 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step
  // one request cycle, then sample just after the answering edge
  task automatic fire(input logic [14:0] m, input logic [11:0] v);
    @(posedge clk_in);
    pl <= m;
    val <= v;
    @(posedge clk_in);
    pl <= 15'h0000;
    #1;
  endtask : fire
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    step(2);
    chk(power_up_mode_select_out, 4'h2, "reset mode");
    chk(probe_active_out, 1'b1, "boot probe");
    fire(PD, 12'h000);
    step(1);
    chk(probe_active_out, 1'b0, "probe end");
    fire(RQ, 12'h000);
    chk(probe_max_current_out, 1'b1, "probe current");
    fire(PD, 12'h000);
    fire(FB, 12'h000);
    chk(probe_active_out, 1'b1, "config probe");
    fire(PD, 12'h000);
    fire(PK, 12'h258);
    chk(peak_current_out, 12'h258, "peak");
    chk(nv_write_out, 1'b1, "peak commit");
    p_exp = 9'h001;
    foreach (pv[i]) begin
      if (pv[i] != 9'h000) p_exp = pv[i];
      fire(PW, {3'h0, pv[i]});
      step(1);
      chk(protocol_word_out, p_exp, "proto word");
      chk(proto_standard_out, p_exp == 9'h001, "standard");
      chk(proto_addr_prefix_out, p_exp[1], "addr");
      chk(proto_ack_nak_out, p_exp[2], "ack");
      chk(proto_reg3_out, p_exp[5], "reg3");
      chk(proto_checksum_out, p_exp[3], "csum");
      chk(proto_csum_alt_out, p_exp[6], "csum kind");
      chk(proto_little_endian_out, p_exp[7], "endian");
      chk(proto_full_duplex_out, p_exp[8], "duplex");
      fire(PQ, 12'h000);
      chk(proto_reply_out, p_exp, "reply");
    end
    fire(VQ, 12'h000);
    chk(vacancy_valid_out, 1'b1, "vacancy pulse");
    chk(vacancy_out, 4'h8, "vacancy idle");
    fire(PA, 12'h000);
    chk(queue_paused_out, 1'b1, "paused");
    for (int i = 0; i < 9; i++) fire(PU, 12'h0A0 + 12'(i));
    fire(VQ, 12'h000);
    chk(vacancy_out, 4'h0, "vacancy full");
    chk(queue_full_out, 1'b1, "full");
    chk(exec_valid_out, 1'b0, "held");
    fire(CO, 12'h000);
    for (w = 0; w < 200 && partner.got.size() < 8; w++) step(1);
    if (w == 200) begin
      num_errors++;
      test_done();
    end
    step(8);
    chk(12'(partner.got.size()), 12'h008, "issued count");
    for (int i = 0; i < 8; i++) chk(partner.got[i], 12'h0A0 + 12'(i), "order");
    m_exp = 4'h2;
    for (int c = 0; c < 16; c++) begin
      if (!(c == 0 || c == 6 || c > 10)) m_exp = c[3:0];
      fire(MW, 12'(c));
      chk(power_up_mode_select_out, m_exp, "mode");
      chk(mode_error_out, c == 0 || c == 6 || c > 10, "mode error");
      step(1);
      chk(autorun_out, m_exp == 4'h7 || m_exp == 4'h9, "autorun");
      chk(modbus_mode_out, m_exp inside {4'h8, 4'h9, 4'hA}, "modbus");
      chk(hub_mode_out, m_exp == 4'h4, "hub");
      chk(drive_enable_out, !(m_exp inside {4'h5, 4'hA}), "en");
    end
    fire(MW | LD, 12'h007);
    chk(power_up_mode_select_out, 4'h1, "download mode");
    fire(CV, 12'h000);
    chk(cmd_accept_out, 1'b0, "gated");
    fire(UP, 12'h000);
    fire(RX, 12'h030);
    fire(RX, 12'h031);
    fire(RX, 12'h030);
    fire(CV, 12'h000);
    chk(cmd_accept_out, 1'b0, "cancelled escape");
    fire(UP, 12'h000);
    fire(RX, 12'h030);
    fire(RX, 12'h030);
    step(2);
    fire(CV, 12'h000);
    chk(cmd_accept_out, 1'b1, "escaped");
    chk(cmd_lang_active_out, 1'b1, "cmd lang");
    chk(power_up_mode_select_out, 4'h1, "mode kept");
    test_done();
  end
endmodule : tb_drive_host_command_config
